// File: hw/qec_pkg.sv
package qec_pkg;

   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [11:0] OFS_ENGINE_CFG    = 12'h700;
   localparam logic [11:0] OFS_RX_TX_CTL     = 12'h704;
   localparam logic [11:0] OFS_MAX_THR       = 12'h710;
   localparam logic [11:0] OFS_LOW_LOSS_THR  = 12'h714;
   localparam logic [11:0] OFS_HIGH_LOSS_THR = 12'h718;
   localparam logic [11:0] OFS_ALT_LEN       = 12'h71C;
   localparam logic [11:0] OFS_PATROL_RANGE  = 12'h720;
   localparam logic [11:0] OFS_TEARDOWN_ID   = 12'h724;
   localparam logic [11:0] OFS_STATUS        = 12'h728;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int BIT_RUN_ENABLE   = 31;
   localparam int BIT_ACTIVE       = 30;
   localparam int BIT_SINGLE_STEP  = 29;
   localparam int BIT_WAN_EG_IGN   = 0;
   localparam int BIT_LOOP_EG_IGN  = 4;
   localparam int BIT_WAN_IN_IGN   = 8;
   localparam int BIT_WAN_HOST     = 9;
   localparam int BIT_LOOP_IN_IGN  = 12;
   localparam int BIT_LOOP_HOST    = 13;
   localparam int BIT_PATROL_RUN   = 0;
   localparam int BIT_TD_RUN       = 4;
   localparam int BIT_TD_SCOPE     = 5;

   // ------------------------------------------------------------
   // writable masks and reset values
   // ------------------------------------------------------------
   localparam logic [31:0] MASK_RX_TX   = 32'h0000_3311;
   localparam logic [31:0] MASK_THR     = 32'h00FF_00FF;
   localparam logic [31:0] MASK_ALT_LEN = 32'h0000_03FF;
   localparam logic [31:0] MASK_TD_ID   = 32'hFFFF_FFF3;
   localparam logic [31:0] RESET_VALUE  = 32'h0000_0000;

   // ------------------------------------------------------------
   // engine step counts
   // ------------------------------------------------------------
   localparam logic [7:0] TD_CYCLES     = 8'h10;
   localparam logic [7:0] STEP_CYCLES   = 8'h04;

   typedef enum logic [1:0] {QEC_CELL_TO_WAN, QEC_CELL_TO_LOOP, QEC_CELL_TO_HOST} qec_dest_t;

endpackage : qec_pkg

// File: hw/qec_engine_if.sv
`timescale 1ns/100ps
interface qec_engine_if;
   logic        patrol_start;
   logic [15:0] patrol_first_conn;
   logic [15:0] patrol_last_conn;
   logic        patrol_done;
   logic [15:0] patrol_conn;
   logic        patrol_check;
   modport ctl (output patrol_start, patrol_first_conn, patrol_last_conn,
                input  patrol_done, patrol_conn, patrol_check);
   modport walk (input  patrol_start, patrol_first_conn, patrol_last_conn,
                 output patrol_done, patrol_conn, patrol_check);
endinterface : qec_engine_if

// File: hw/qec_patrol_walker.sv
`timescale 1ns/100ps
module qec_patrol_walker (
   // clock and reset
   input  wire logic   clock,
   input  wire logic   rst,
   // control side
   qec_engine_if.walk  eng
);

   typedef enum logic [0:0] {QEC_IDLE, QEC_WALK} qec_walk_t;

   qec_walk_t   state_q;
   logic [15:0] conn_q;
   logic        done_q;
   wire         at_end = (conn_q == eng.patrol_last_conn);

   // ------------------------------------------------------------
   // walk connection ids first..last
   // ------------------------------------------------------------
   always_ff @(posedge clock) begin
      done_q <= 1'b0;
      if (rst) begin
         state_q <= QEC_IDLE;
         conn_q  <= 16'h0000;
      end else begin
         case (state_q)
            QEC_IDLE: begin
               if (eng.patrol_start) begin
                  conn_q  <= eng.patrol_first_conn;
                  state_q <= QEC_WALK;
               end
            end
            QEC_WALK: begin
               if (at_end || conn_q > eng.patrol_last_conn) begin
                  done_q  <= 1'b1;
                  state_q <= QEC_IDLE;
               end else begin
                  conn_q <= conn_q + 16'h0001;
               end
            end
            default: state_q <= QEC_IDLE;
         endcase
      end
   end

   assign eng.patrol_done  = done_q;
   assign eng.patrol_conn  = conn_q;
   assign eng.patrol_check = state_q[0];

endmodule : qec_patrol_walker

// File: hw/qec_queue_engine_regs.sv
`timescale 1ns/100ps
module qec_queue_engine_regs (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        rst,
   // register port
   input  wire logic [11:0] reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   // cell requests
   input  wire logic        wan_egress_req,
   input  wire logic        loop_egress_req,
   input  wire logic        wan_ingress_req,
   input  wire logic        loop_ingress_req,
   input  wire logic [1:0]  ingress_dest,
   // frame check
   input  wire logic        frame_check,
   input  wire logic        frame_continuous,
   input  wire logic        alt_length_select,
   input  wire logic [15:0] frame_cells,
   // engine outputs
   output logic             wan_egress_grant,
   output logic             loop_egress_grant,
   output logic             wan_ingress_grant,
   output logic             loop_ingress_grant,
   output logic             ingress_discard,
   output logic             early_frame_discard,
   output logic [15:0]      discard_count,
   output logic             teardown_strobe,
   output logic             teardown_scope_select,
   output logic [15:0]      teardown_conn_id,
   output logic [11:0]      teardown_port_id,
   output logic [1:0]       teardown_class_id,
   output logic [15:0]      patrol_conn,
   output logic             patrol_check,
   output logic [7:0]       wan_total_limit,
   output logic [7:0]       loop_total_limit,
   output logic [7:0]       wan_low_loss_discard_level,
   output logic [7:0]       loop_low_loss_discard_level,
   output logic [7:0]       wan_high_loss_discard_level,
   output logic [7:0]       loop_high_loss_discard_level,
   output logic             engine_active_flag
);

   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   logic        run_q;
   logic        step_q;
   logic        active_q;
   logic [7:0]  step_cnt_q;
   logic [31:0] rx_tx_q;
   logic [31:0] max_thr_q;
   logic [31:0] low_thr_q;
   logic [31:0] high_thr_q;
   logic [31:0] alt_len_q;
   logic [31:0] patrol_range_q;
   logic [31:0] td_id_q;
   logic        patrol_run_q;
   logic        td_run_q;
   logic        td_scope_q;
   logic [7:0]  td_cnt_q;
   logic        patrol_start_q;
   logic [31:0] rdata_q;
   logic [15:0] disc_cnt_q;
   logic        wan_eg_q, loop_eg_q, wan_in_q, loop_in_q, in_disc_q, efd_q, td_strobe_q;

   qec_engine_if eng ();

   qec_patrol_walker u_walker (
      .clock (clock),
      .rst   (rst),
      .eng   (eng)
   );

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   wire wr_cfg    = reg_wr && reg_addr == qec_pkg::OFS_ENGINE_CFG;
   wire wr_rx_tx  = reg_wr && reg_addr == qec_pkg::OFS_RX_TX_CTL;
   wire wr_max    = reg_wr && reg_addr == qec_pkg::OFS_MAX_THR;
   wire wr_low    = reg_wr && reg_addr == qec_pkg::OFS_LOW_LOSS_THR;
   wire wr_high   = reg_wr && reg_addr == qec_pkg::OFS_HIGH_LOSS_THR;
   wire wr_alt    = reg_wr && reg_addr == qec_pkg::OFS_ALT_LEN;
   wire wr_range  = reg_wr && reg_addr == qec_pkg::OFS_PATROL_RANGE;
   wire wr_td_id  = reg_wr && reg_addr == qec_pkg::OFS_TEARDOWN_ID;
   wire wr_status = reg_wr && reg_addr == qec_pkg::OFS_STATUS;

   wire engine_on = run_q || active_q;
   wire step_go   = step_q && !active_q;
   wire td_go     = wr_status && reg_wdata[qec_pkg::BIT_TD_RUN] && !td_run_q;
   wire pt_go     = wr_status && reg_wdata[qec_pkg::BIT_PATROL_RUN] && !patrol_run_q;
   wire td_end    = td_run_q && td_cnt_q == qec_pkg::TD_CYCLES;
   wire step_end  = active_q && step_q && step_cnt_q == qec_pkg::STEP_CYCLES;
   wire in_busy   = engine_on || td_run_q || patrol_run_q;

   wire wan_switched  = ingress_dest != 2'(qec_pkg::QEC_CELL_TO_HOST);
   wire wan_in_ok     = engine_on && wan_ingress_req && !rx_tx_q[qec_pkg::BIT_WAN_IN_IGN];
   wire loop_in_ok    = engine_on && loop_ingress_req && !rx_tx_q[qec_pkg::BIT_LOOP_IN_IGN];
   wire wan_filtered  = wan_in_ok && rx_tx_q[qec_pkg::BIT_WAN_HOST] && wan_switched;
   wire loop_filtered = loop_in_ok && rx_tx_q[qec_pkg::BIT_LOOP_HOST] && wan_switched;
   wire efd_hit       = engine_on && frame_check && frame_continuous && alt_length_select
                        && frame_cells > {6'h00, alt_len_q[9:0]};
   wire [15:0] disc_inc = 16'(wan_filtered) + 16'(loop_filtered) + 16'(td_end);

   logic [31:0] rd_mux;
   always_comb begin
      case (reg_addr)
         qec_pkg::OFS_ENGINE_CFG:    rd_mux = {run_q, in_busy, step_q, 29'h0000_0000};
         qec_pkg::OFS_RX_TX_CTL:     rd_mux = rx_tx_q;
         qec_pkg::OFS_MAX_THR:       rd_mux = max_thr_q;
         qec_pkg::OFS_LOW_LOSS_THR:  rd_mux = low_thr_q;
         qec_pkg::OFS_HIGH_LOSS_THR: rd_mux = high_thr_q;
         qec_pkg::OFS_ALT_LEN:       rd_mux = alt_len_q;
         qec_pkg::OFS_PATROL_RANGE:  rd_mux = patrol_range_q;
         qec_pkg::OFS_TEARDOWN_ID:   rd_mux = td_id_q;
         qec_pkg::OFS_STATUS:
            rd_mux = {26'h000_0000, td_scope_q, td_run_q, 3'h0, patrol_run_q};
         default:                    rd_mux = 32'h0000_0000;
      endcase
   end

   // ------------------------------------------------------------
   // engine control and single step
   // ------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         run_q      <= 1'b0;
         step_q     <= 1'b0;
         active_q   <= 1'b0;
         step_cnt_q <= 8'h00;
      end else begin
         if (wr_cfg) begin
            run_q  <= reg_wdata[qec_pkg::BIT_RUN_ENABLE] | reg_wdata[qec_pkg::BIT_SINGLE_STEP];
            step_q <= reg_wdata[qec_pkg::BIT_SINGLE_STEP];
         end
         if (step_go && run_q) begin
            active_q   <= 1'b1;
            step_cnt_q <= 8'h00;
            run_q      <= 1'b0;
         end else if (step_end) begin
            active_q <= 1'b0;
            step_q   <= 1'b0;
            run_q    <= 1'b0;
         end else if (active_q) begin
            step_cnt_q <= step_cnt_q + 8'h01;
         end
      end
   end

   // ------------------------------------------------------------
   // plain registers
   // ------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         rx_tx_q        <= qec_pkg::RESET_VALUE;
         max_thr_q      <= qec_pkg::RESET_VALUE;
         low_thr_q      <= qec_pkg::RESET_VALUE;
         high_thr_q     <= qec_pkg::RESET_VALUE;
         alt_len_q      <= qec_pkg::RESET_VALUE;
         patrol_range_q <= qec_pkg::RESET_VALUE;
         td_id_q        <= qec_pkg::RESET_VALUE;
         td_scope_q     <= 1'b0;
      end else begin
         if (wr_rx_tx) rx_tx_q <= reg_wdata & qec_pkg::MASK_RX_TX;
         if (wr_max) max_thr_q <= reg_wdata & qec_pkg::MASK_THR;
         if (wr_low) low_thr_q <= reg_wdata & qec_pkg::MASK_THR;
         if (wr_high) high_thr_q <= reg_wdata & qec_pkg::MASK_THR;
         if (wr_alt) alt_len_q <= reg_wdata & qec_pkg::MASK_ALT_LEN;
         if (wr_range) patrol_range_q <= reg_wdata;
         if (wr_td_id) td_id_q <= reg_wdata & qec_pkg::MASK_TD_ID;
         if (wr_status) td_scope_q <= reg_wdata[qec_pkg::BIT_TD_SCOPE];
      end
   end

   // ------------------------------------------------------------
   // patrol and tear-down status
   // ------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         patrol_run_q   <= 1'b0;
         patrol_start_q <= 1'b0;
         td_run_q       <= 1'b0;
         td_cnt_q       <= 8'h00;
      end else begin
         patrol_start_q <= pt_go;
         if (pt_go) patrol_run_q <= 1'b1;
         else if (eng.patrol_done) patrol_run_q <= 1'b0;
         if (td_go) begin
            td_run_q <= 1'b1;
            td_cnt_q <= 8'h00;
         end else if (td_end) begin
            td_run_q <= 1'b0;
         end else if (td_run_q) begin
            td_cnt_q <= td_cnt_q + 8'h01;
         end
      end
   end

   assign eng.patrol_start      = patrol_start_q;
   assign eng.patrol_first_conn = patrol_range_q[15:0];
   assign eng.patrol_last_conn  = patrol_range_q[31:16];

   // ------------------------------------------------------------
   // request gating, discards, read data
   // ------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         wan_eg_q    <= 1'b0;
         loop_eg_q   <= 1'b0;
         wan_in_q    <= 1'b0;
         loop_in_q   <= 1'b0;
         in_disc_q   <= 1'b0;
         efd_q       <= 1'b0;
         td_strobe_q <= 1'b0;
         disc_cnt_q  <= 16'h0000;
         rdata_q     <= 32'h0000_0000;
      end else begin
         wan_eg_q    <= engine_on && wan_egress_req && !rx_tx_q[qec_pkg::BIT_WAN_EG_IGN];
         loop_eg_q   <= engine_on && loop_egress_req
                        && !rx_tx_q[qec_pkg::BIT_LOOP_EG_IGN];
         wan_in_q    <= wan_in_ok && !wan_filtered;
         loop_in_q   <= loop_in_ok && !loop_filtered;
         in_disc_q   <= wan_filtered || loop_filtered;
         efd_q       <= efd_hit;
         td_strobe_q <= td_end;
         disc_cnt_q  <= disc_cnt_q + disc_inc;
         rdata_q     <= reg_rd ? rd_mux : 32'h0000_0000;
      end
   end

   assign reg_rdata                    = rdata_q;
   assign wan_egress_grant             = wan_eg_q;
   assign loop_egress_grant            = loop_eg_q;
   assign wan_ingress_grant            = wan_in_q;
   assign loop_ingress_grant           = loop_in_q;
   assign ingress_discard              = in_disc_q;
   assign early_frame_discard          = efd_q;
   assign discard_count                = disc_cnt_q;
   assign teardown_strobe              = td_strobe_q;
   assign teardown_scope_select        = td_scope_q;
   assign teardown_conn_id             = td_id_q[31:16];
   assign teardown_port_id             = td_id_q[15:4];
   assign teardown_class_id            = td_id_q[1:0];
   assign patrol_conn                  = eng.patrol_conn;
   assign patrol_check                 = eng.patrol_check;
   assign wan_total_limit              = max_thr_q[7:0];
   assign loop_total_limit             = max_thr_q[23:16];
   assign wan_low_loss_discard_level   = low_thr_q[7:0];
   assign loop_low_loss_discard_level  = low_thr_q[23:16];
   assign wan_high_loss_discard_level  = high_thr_q[7:0];
   assign loop_high_loss_discard_level = high_thr_q[23:16];
   assign engine_active_flag           = active_q;

endmodule : qec_queue_engine_regs

// File: testbench/qec_queue_engine_regs_checker.sv
`timescale 1ns/100ps
module qec_regs_checker (
   // clock and register port
   input wire logic        clock,
   input wire logic        rst,
   input wire logic [11:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   // cell and frame inputs
   input wire logic        wan_egress_req,
   input wire logic        loop_egress_req,
   input wire logic        wan_ingress_req,
   input wire logic        loop_ingress_req,
   input wire logic [1:0]  ingress_dest,
   input wire logic        frame_check,
   input wire logic        frame_continuous,
   input wire logic        alt_length_select,
   input wire logic [15:0] frame_cells,
   // engine outputs
   input wire logic        wan_egress_grant,
   input wire logic        loop_egress_grant,
   input wire logic        wan_ingress_grant,
   input wire logic        loop_ingress_grant,
   input wire logic        ingress_discard,
   input wire logic        early_frame_discard,
   input wire logic [15:0] discard_count,
   input wire logic        teardown_strobe,
   input wire logic [15:0] patrol_conn,
   input wire logic        patrol_check
);
   logic [31:0] ctl_q;
   logic [9:0]  alt_q;
   logic [15:0] first_q;
   logic        td_q;
   wire         wr_ctl   = reg_wr && reg_addr == qec_pkg::OFS_RX_TX_CTL;
   wire         wr_alt   = reg_wr && reg_addr == qec_pkg::OFS_ALT_LEN;
   wire         wr_range = reg_wr && reg_addr == qec_pkg::OFS_PATROL_RANGE;
   wire         td_start = reg_wr && reg_addr == qec_pkg::OFS_STATUS && reg_wdata[4] && !td_q;

   // ----------------------------------------
   // shadow of host-written fields
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         ctl_q   <= 32'h0000_0000;
         alt_q   <= 10'h000;
         first_q <= 16'h0000;
         td_q    <= 1'b0;
      end else begin
         if (wr_ctl) ctl_q <= reg_wdata;
         if (wr_alt) alt_q <= reg_wdata[9:0];
         if (wr_range) first_q <= reg_wdata[15:0];
         if (td_start) td_q <= 1'b1;
         else if (teardown_strobe) td_q <= 1'b0;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   AST_WAN_EG_IGNORE: assert property (wan_egress_grant |-> $past(wan_egress_req && !ctl_q[0]))
      else $error("wan egress grant without an accepted request");
   AST_LOOP_EG_IGNORE: assert property (loop_egress_grant |-> $past(loop_egress_req && !ctl_q[4]))
      else $error("loop egress grant without an accepted request");
   AST_WAN_IN_IGNORE: assert property (wan_ingress_grant |-> $past(wan_ingress_req && !ctl_q[8]))
      else $error("wan ingress grant without an accepted request");
   AST_LOOP_IN_IGNORE: assert property (loop_ingress_grant |-> $past(loop_ingress_req && !ctl_q[12]))
      else $error("loop ingress grant without an accepted request");
   AST_HOST_FILTER: assert property (ingress_discard |-> $past(ingress_dest) != 2'h2 &&
      $past((wan_ingress_req && ctl_q[9] && !ctl_q[8]) || (loop_ingress_req && ctl_q[13] && !ctl_q[12])))
      else $error("ingress discard without a filtered switched cell");
   AST_FRAME_DISCARD: assert property (early_frame_discard == $past(frame_check && frame_continuous
      && alt_length_select && frame_cells > {6'h00, alt_q})) else $error("frame discard mismatch");
   AST_COUNT_STEP: assert property (discard_count != $past(discard_count) |->
      (teardown_strobe || ingress_discard) && discard_count == $past(discard_count) + 16'h0001)
      else $error("discard count moved without cause");
   AST_TD_DONE: assert property (td_start |-> ##[1:24] teardown_strobe)
      else $error("tear-down did not complete in time");
   AST_TD_CAUSE: assert property (teardown_strobe |-> td_q)
      else $error("tear-down strobe without a start");
   AST_PATROL_FIRST: assert property ($rose(patrol_check) |-> patrol_conn == first_q)
      else $error("patrol began at a wrong id");
   AST_PATROL_STEP: assert property (patrol_check && $past(patrol_check) |->
      patrol_conn == $past(patrol_conn) + 16'h0001) else $error("patrol skipped an id");

   cover property (ingress_discard);
   cover property (early_frame_discard);
   cover property (teardown_strobe);
   cover property ($rose(patrol_check));
endmodule : qec_regs_checker

// File: testbench/qec_host_model.sv
`timescale 1ns/100ps
module qec_host_model (
   // clock
   input  wire logic        clock,
   // register port
   output logic      [11:0] reg_addr,
   output logic      [31:0] reg_wdata,
   output logic             reg_wr,
   output logic             reg_rd,
   input  wire logic [31:0] reg_rdata
);
   initial begin
      reg_addr  = 12'h000;
      reg_wdata = 32'h0000_0000;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
   end

   // idle address and data show the inverse so stale values never match
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clock);
      reg_wr    <= 1'b0;
      reg_addr  <= ~a;
      reg_wdata <= ~d;
   endtask : wr

   task automatic rd(input logic [11:0] a, output logic [31:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clock);
      reg_rd   <= 1'b0;
      reg_addr <= ~a;
      #1;
      d = reg_rdata;
   endtask : rd
endmodule : qec_host_model

// File: testbench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
   logic        clock, rst, reg_wr, reg_rd, frame_check, frame_continuous, alt_length_select;
   logic [11:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, rd_q;
   logic [3:0]  req, seen;
   logic [1:0]  ingress_dest;
   logic [15:0] frame_cells, cnt, p_first, p_last, p_n;
   logic        dseen;
   wire  [3:0]  grant;
   wire  [7:0]  lim [6];
   wire         ingress_discard, early_frame_discard, teardown_strobe, teardown_scope_select;
   wire  [15:0] discard_count, teardown_conn_id, patrol_conn;
   wire  [11:0] teardown_port_id;
   wire  [1:0]  teardown_class_id;
   wire         patrol_check, engine_active_flag;
   int          n_errors, n_checks;
   localparam logic [11:0] RW_ADDR [7] = '{qec_pkg::OFS_RX_TX_CTL, qec_pkg::OFS_MAX_THR,
      qec_pkg::OFS_LOW_LOSS_THR, qec_pkg::OFS_HIGH_LOSS_THR, qec_pkg::OFS_ALT_LEN,
      qec_pkg::OFS_PATROL_RANGE, qec_pkg::OFS_TEARDOWN_ID};
   localparam logic [31:0] RW_MASK [7] = '{qec_pkg::MASK_RX_TX, qec_pkg::MASK_THR,
      qec_pkg::MASK_THR, qec_pkg::MASK_THR, qec_pkg::MASK_ALT_LEN, 32'hFFFF_FFFF, qec_pkg::MASK_TD_ID};

   qec_host_model host (.clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   qec_queue_engine_regs dut (.clock(clock), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .wan_egress_req(req[0]), .loop_egress_req(req[1]), .wan_ingress_req(req[2]),
      .loop_ingress_req(req[3]), .ingress_dest(ingress_dest), .frame_check(frame_check),
      .frame_continuous(frame_continuous), .alt_length_select(alt_length_select),
      .frame_cells(frame_cells), .wan_egress_grant(grant[0]), .loop_egress_grant(grant[1]),
      .wan_ingress_grant(grant[2]), .loop_ingress_grant(grant[3]),
      .ingress_discard(ingress_discard), .early_frame_discard(early_frame_discard),
      .discard_count(discard_count), .teardown_strobe(teardown_strobe),
      .teardown_scope_select(teardown_scope_select), .teardown_conn_id(teardown_conn_id),
      .teardown_port_id(teardown_port_id), .teardown_class_id(teardown_class_id),
      .patrol_conn(patrol_conn), .patrol_check(patrol_check), .wan_total_limit(lim[0]),
      .loop_total_limit(lim[1]), .wan_low_loss_discard_level(lim[2]),
      .loop_low_loss_discard_level(lim[3]), .wan_high_loss_discard_level(lim[4]),
      .loop_high_loss_discard_level(lim[5]), .engine_active_flag(engine_active_flag));

   initial clock = 1'b0;
   always #12.5 clock = ~clock;
   always @(posedge clock) if (patrol_check === 1'b1) begin
      if (p_n == 16'h0000) p_first <= patrol_conn;
      p_last <= patrol_conn;
      p_n    <= p_n + 16'h0001;
   end

   // ----------------------------------------
   // checking and access helpers
   // ----------------------------------------
   task automatic end_of_test;
      $display("mismatches %0d, comparisons %0d", n_errors, n_checks);
      if (n_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
      host.rd(a, rd_q);
      chk(rd_q, exp);
   endtask : rchk
   // one-cycle request, responses gathered over three cycles
   task automatic pulse(input logic [3:0] r, input logic [1:0] d);
      @(posedge clock);
      req          <= r;
      ingress_dest <= d;
      @(posedge clock);
      req   <= 4'h0;
      seen  = 4'h0;
      dseen = 1'b0;
      repeat (3) begin
         #1;
         seen  = seen | grant;
         dseen = dseen | ingress_discard;
         @(posedge clock);
      end
   endtask : pulse
   task automatic wait_for(input bit strobe_sel, input logic lvl);
      for (int n = 0; n < 60; n++) begin
         @(posedge clock);
         #1;
         if ((strobe_sel ? teardown_strobe : engine_active_flag) === lvl) return;
      end
      chk(32'h0, 32'h1);
      end_of_test();
   endtask : wait_for

   initial begin
      {rst, req, ingress_dest, frame_check, frame_continuous, alt_length_select} = '1;
      {req, ingress_dest, frame_check, frame_continuous, alt_length_select} = '0;
      {frame_cells, p_n, n_errors, n_checks} = '0;
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      for (int i = 0; i < 7; i++) rchk(RW_ADDR[i], 32'h0000_0000);
      rchk(qec_pkg::OFS_STATUS, 32'h0000_0000);
      rchk(qec_pkg::OFS_ENGINE_CFG, 32'h0000_0000);
      for (int i = 0; i < 7; i++) begin
         host.wr(RW_ADDR[i], 32'hFFFF_FFFF);
         rchk(RW_ADDR[i], RW_MASK[i]);
      end
      host.wr(12'h7F0, 32'hFFFF_FFFF);
      rchk(12'h7F0, 32'h0000_0000);
      host.wr(qec_pkg::OFS_MAX_THR, 32'h0012_0034);
      host.wr(qec_pkg::OFS_LOW_LOSS_THR, 32'h0056_0078);
      host.wr(qec_pkg::OFS_HIGH_LOSS_THR, 32'h009A_00BC);
      #1;
      chk({lim[1], lim[0], lim[3], lim[2]}, 32'h1234_5678);
      chk({lim[5], lim[4]}, 32'h0000_9ABC);
      // grants: engine off, then each ignore bit alone
      host.wr(qec_pkg::OFS_RX_TX_CTL, 32'h0000_0000);
      pulse(4'hF, 2'h0);
      chk(seen, 4'h0);
      host.wr(qec_pkg::OFS_ENGINE_CFG, 32'h8000_0000);
      for (int i = 0; i < 4; i++) begin
         host.wr(qec_pkg::OFS_RX_TX_CTL, 32'h1 << (4 * i));
         pulse(4'hF, 2'h0);
         chk(seen, 4'hF & ~(4'h1 << i));
      end
      for (int i = 0; i < 2; i++) begin
         host.wr(qec_pkg::OFS_RX_TX_CTL, 32'h200 << (4 * i));
         cnt = discard_count;
         pulse(4'h4 << i, 2'(1 - i));
         chk({dseen, seen, discard_count}, {1'b1, 4'h0, cnt + 16'h1});
         pulse(4'h4 << i, 2'h2);
         chk({dseen, seen, discard_count}, {1'b0, 4'h4 << i, cnt + 16'h1});
      end
      host.wr(qec_pkg::OFS_ALT_LEN, 32'h0000_000A);
      for (int i = 0; i < 4; i++) begin
         @(posedge clock);
         frame_check       <= 1'b1;
         frame_continuous  <= (i != 2);
         alt_length_select <= (i != 3);
         frame_cells       <= (i == 0) ? 16'h000A : 16'h000B;
         @(posedge clock);
         frame_check <= 1'b0;
         #1;
         chk(early_frame_discard, i == 1);
      end
      // tear-down run bit stays set while a tear-down runs
      host.wr(qec_pkg::OFS_TEARDOWN_ID, 32'h1234_567B);
      #1;
      chk({teardown_conn_id, teardown_port_id, 2'h0, teardown_class_id}, 32'h1234_5673);
      for (int m = 0; m < 2; m++) begin
         cnt = discard_count;
         host.wr(qec_pkg::OFS_STATUS, 32'h10 | (m << 5));
         host.wr(qec_pkg::OFS_STATUS, 32'h00 | (m << 5));
         rchk(qec_pkg::OFS_STATUS, 32'h10 | (m << 5));
         chk(teardown_scope_select, m[0]);
         wait_for(1'b1, 1'b1);
         #1;
         chk(discard_count, cnt + 16'h1);
         rchk(qec_pkg::OFS_STATUS, m << 5);
      end
      // patrol range left alone until the patrol is over
      host.wr(qec_pkg::OFS_PATROL_RANGE, {16'd40, 16'd3});
      host.wr(qec_pkg::OFS_STATUS, 32'h0000_0001);
      host.wr(qec_pkg::OFS_STATUS, 32'h0000_0000);
      rchk(qec_pkg::OFS_STATUS, 32'h0000_0001);
      for (int n = 0; n < 40 && rd_q[0] === 1'b1; n++) host.rd(qec_pkg::OFS_STATUS, rd_q);
      chk(rd_q, 32'h0000_0000);
      chk({p_first, p_last}, {16'd3, 16'd40});
      chk(p_n, 16'd38);
      rchk(qec_pkg::OFS_ENGINE_CFG, 32'hC000_0000);
      host.wr(qec_pkg::OFS_ENGINE_CFG, 32'h2000_0000);
      wait_for(1'b0, 1'b1);
      wait_for(1'b0, 1'b0);
      rchk(qec_pkg::OFS_ENGINE_CFG, 32'h0000_0000);
      pulse(4'hF, 2'h2);
      chk(seen, 4'h0);
      end_of_test();
   end
endmodule : tb_top

bind qec_queue_engine_regs qec_regs_checker chk (.clock(clock), .rst(rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .wan_egress_req(wan_egress_req),
   .loop_egress_req(loop_egress_req), .wan_ingress_req(wan_ingress_req),
   .loop_ingress_req(loop_ingress_req), .ingress_dest(ingress_dest), .frame_check(frame_check),
   .frame_continuous(frame_continuous), .alt_length_select(alt_length_select),
   .frame_cells(frame_cells), .wan_egress_grant(wan_egress_grant),
   .loop_egress_grant(loop_egress_grant), .wan_ingress_grant(wan_ingress_grant),
   .loop_ingress_grant(loop_ingress_grant), .ingress_discard(ingress_discard),
   .early_frame_discard(early_frame_discard), .discard_count(discard_count),
   .teardown_strobe(teardown_strobe), .patrol_conn(patrol_conn), .patrol_check(patrol_check));
